// ==== common/rgu_pkg.sv ====
// restart_guard_unit shared constants: control word layout, key values, reset values.
// assumes a 16-bit peripheral word bus with whole-word writes only from the cpu side.
package rgu_pkg;
  localparam logic [7:0] RGU_KEY_WRITE = 8'h5A;
  localparam logic [7:0] RGU_KEY_READ = 8'h69;
  // low byte of guard_control_word
  localparam int RGU_BIT_HOLD = 7;
  localparam int RGU_BIT_NMI_EDGE = 6;
  localparam int RGU_BIT_NMI_SEL = 5;
  localparam int RGU_BIT_TIMER_MODE = 4;
  localparam int RGU_BIT_CLR = 3;
  localparam int RGU_BIT_ACLK_SEL = 2;
  localparam int RGU_BIT_IS_HI = 1;
  localparam int RGU_BIT_IS_LO = 0;
  localparam logic [7:0] RGU_CTRL_RESET = 8'h00;
  localparam int RGU_CNT_W = 16;
  // tap positions (interval = 2^(tap+1) clocks) selected by the two IS bits
  localparam int RGU_TAP_0 = 15;
  localparam int RGU_TAP_1 = 12;
  localparam int RGU_TAP_2 = 8;
  localparam int RGU_TAP_3 = 5;
  localparam logic [RGU_CNT_W-1:0] RGU_CNT_RESET = 16'h0000;
  // length of the generated power_up_clear_reset pulse in sys_clk cycles
  localparam logic [3:0] RGU_PUC_CYCLES = 4'h4;
  typedef enum logic [1:0] {
    RGU_ST_RUN = 2'b01,
    RGU_ST_PUC = 2'b10
  } rgu_state_t;
endpackage

// ==== design/rgu_sync.sv ====
// rgu_sync: two-flop synchroniser for a level from outside the sys_clk domain.
// assumes the level is stable for at least two sys_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module rgu_sync
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  always_comb
  begin
    meta_next = d_in;
    q_next = meta_reg;
    if (!rstn)
    begin
      meta_next = 1'b0;
      q_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    meta_reg <= meta_next;
    q_reg <= q_next;
  end

  assign q_out = q_reg;
endmodule
`default_nettype wire

// ==== design/rgu_watchdog.sv ====
// restart_guard_unit: password-guarded watchdog / interval timer with pin config bits.
// assumes a cpu peripheral port (sel, wr, 16-bit data) on sys_clk; clock sources as enables.
// Function
// RULE1: in watchdog mode, counter expiry produces a full system reset.
// RULE2: in interval-timer mode, expiry raises an interrupt request instead of reset.
// RULE3: interval counter is 16-bit incrementing and not visible to software.
// RULE4: one 8-bit read/write control register steers the counter.
// RULE5: every control write must carry key 05Ah in the high byte.
// RULE6: a write with any other high byte triggers a power-up-clear reset.
// RULE7: reads return 069h in the high byte.
// RULE8: a correctly keyed write stores its low byte as control settings.
// RULE9: control register also holds two bits configuring the reset/nmi pin.
// RULE10: event flag sets on counter overflow and on key violation.
// RULE11: event flag clears on power-on or reset at the reset/nmi pin.
// RULE12: interval interrupt only issued while the separate enable bit is set.
`timescale 1ns/1ps
`default_nettype none
module rgu_watchdog
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic power_on_n,
  input wire logic pin_reset_n,
  input wire logic mclk_tick,
  input wire logic aclk_tick,
  input wire logic ctl_sel,
  input wire logic ctl_wr,
  input wire logic [15:0] ctl_wdata,
  output logic [15:0] ctl_rdata,
  input wire logic flag_clr,
  input wire logic flag_set,
  input wire logic guard_event_enable,
  output logic guard_event_flag,
  output logic guard_irq,
  output logic power_up_clear_reset,
  output logic nmi_select,
  output logic nmi_edge
);
  logic aclk_s;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [rgu_pkg::RGU_CNT_W-1:0] cnt_reg;
  logic [rgu_pkg::RGU_CNT_W-1:0] cnt_next;
  logic flag_reg;
  logic flag_next;
  logic irq_reg;
  logic irq_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [3:0] puc_cnt_reg;
  logic [3:0] puc_cnt_next;
  rgu_pkg::rgu_state_t state_reg;
  rgu_pkg::rgu_state_t state_next;
  logic tick;
  logic tap;
  logic tap_prev_reg;
  logic tap_prev_next;
  logic expire;
  logic key_ok;
  logic key_bad;
  logic puc_req;
  logic puc_reg;
  logic puc_next;

  // aclk edge arrives from another clock, so it is synchronised first
  rgu_sync u_aclk_sync
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d_in(aclk_tick),
    .q_out(aclk_s)
  );

  always_comb
  begin
    key_ok = ctl_sel && ctl_wr && (ctl_wdata[15:8] == rgu_pkg::RGU_KEY_WRITE); // RULE5
    key_bad = ctl_sel && ctl_wr && (ctl_wdata[15:8] != rgu_pkg::RGU_KEY_WRITE); // RULE6
    tick = ctrl_reg[rgu_pkg::RGU_BIT_ACLK_SEL] ? aclk_s : mclk_tick;
    case (ctrl_reg[rgu_pkg::RGU_BIT_IS_HI:rgu_pkg::RGU_BIT_IS_LO])
      2'b00: tap = cnt_reg[rgu_pkg::RGU_TAP_0];
      2'b01: tap = cnt_reg[rgu_pkg::RGU_TAP_1];
      2'b10: tap = cnt_reg[rgu_pkg::RGU_TAP_2];
      default: tap = cnt_reg[rgu_pkg::RGU_TAP_3];
    endcase
    // falling edge of the tap bit marks the end of the interval
    expire = tap_prev_reg && !tap;
    puc_req = key_bad || (expire && !ctrl_reg[rgu_pkg::RGU_BIT_TIMER_MODE]); // RULE1 RULE6
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    cnt_next = cnt_reg;
    tap_prev_next = tap;
    if (key_ok)
    begin
      ctrl_next = ctl_wdata[7:0]; // RULE4 RULE8 RULE9
      ctrl_next[rgu_pkg::RGU_BIT_CLR] = 1'b0;
    end
    // counter clear bit is self-clearing and restarts the interval
    if (key_ok && ctl_wdata[rgu_pkg::RGU_BIT_CLR])
    begin
      cnt_next = rgu_pkg::RGU_CNT_RESET;
      tap_prev_next = 1'b0;
    end
    else if (tick && !ctrl_reg[rgu_pkg::RGU_BIT_HOLD])
    begin
      cnt_next = cnt_reg + 16'h0001; // RULE3
    end
    if (!rstn || state_reg == rgu_pkg::RGU_ST_PUC)
    begin
      ctrl_next = rgu_pkg::RGU_CTRL_RESET;
      cnt_next = rgu_pkg::RGU_CNT_RESET;
      tap_prev_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    ctrl_reg <= ctrl_next;
    cnt_reg <= cnt_next;
    tap_prev_reg <= tap_prev_next;
  end

  // flag survives power_up_clear so software can find the restart cause
  always_comb
  begin
    flag_next = flag_reg;
    irq_next = 1'b0;
    if (flag_clr)
    begin
      flag_next = 1'b0;
    end
    if (expire || key_bad || flag_set)
    begin
      flag_next = 1'b1; // RULE10
    end
    if (expire && ctrl_reg[rgu_pkg::RGU_BIT_TIMER_MODE] && guard_event_enable)
    begin
      irq_next = 1'b1; // RULE2 RULE12
    end
    if (!power_on_n || !pin_reset_n)
    begin
      flag_next = 1'b0; // RULE11
      irq_next = 1'b0;
    end
    // rstn drops a pending pulse but leaves the restart cause in the flag
    if (!rstn)
    begin
      irq_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    flag_reg <= flag_next;
    irq_reg <= irq_next;
  end

  always_comb
  begin
    state_next = state_reg;
    puc_cnt_next = puc_cnt_reg;
    case (state_reg)
      rgu_pkg::RGU_ST_RUN:
      begin
        if (puc_req)
        begin
          state_next = rgu_pkg::RGU_ST_PUC;
          puc_cnt_next = rgu_pkg::RGU_PUC_CYCLES;
        end
      end
      rgu_pkg::RGU_ST_PUC:
      begin
        puc_cnt_next = puc_cnt_reg - 4'h1;
        if (puc_cnt_reg == 4'h1)
        begin
          state_next = rgu_pkg::RGU_ST_RUN;
        end
      end
      default:
      begin
        state_next = rgu_pkg::RGU_ST_RUN;
        puc_cnt_next = 4'h0;
      end
    endcase
    if (!rstn)
    begin
      state_next = rgu_pkg::RGU_ST_RUN;
      puc_cnt_next = 4'h0;
    end
    // own flop so the reset output carries no decode glitch
    puc_next = (state_next == rgu_pkg::RGU_ST_PUC);
  end

  always_ff @(posedge sys_clk)
  begin
    state_reg <= state_next;
    puc_cnt_reg <= puc_cnt_next;
    puc_reg <= puc_next;
  end

  always_comb
  begin
    rdata_next = {rgu_pkg::RGU_KEY_READ, ctrl_next}; // RULE7
    if (!rstn)
    begin
      rdata_next = {rgu_pkg::RGU_KEY_READ, rgu_pkg::RGU_CTRL_RESET};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rdata_reg <= rdata_next;
  end

  assign ctl_rdata = rdata_reg;
  assign guard_event_flag = flag_reg;
  assign guard_irq = irq_reg;
  assign power_up_clear_reset = puc_reg;
  assign nmi_select = ctrl_reg[rgu_pkg::RGU_BIT_NMI_SEL];
  assign nmi_edge = ctrl_reg[rgu_pkg::RGU_BIT_NMI_EDGE];
endmodule
`default_nettype wire

// ==== sim/rgu_watchdog_assertions.sv ====
// restart_guard_unit port checker
// assumes bind onto rgu_watchdog, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rgu_watchdog_assertions
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic power_on_n,
  input wire logic pin_reset_n,
  input wire logic ctl_sel,
  input wire logic ctl_wr,
  input wire logic [15:0] ctl_wdata,
  input wire logic [15:0] ctl_rdata,
  input wire logic guard_event_enable,
  input wire logic guard_event_flag,
  input wire logic guard_irq,
  input wire logic power_up_clear_reset,
  input wire logic nmi_select,
  input wire logic nmi_edge
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  wire logic wr_go = ctl_sel && ctl_wr;
  wire logic key_ok = ctl_wdata[15:8] == rgu_pkg::RGU_KEY_WRITE;
  sequence puc_pulse;
    power_up_clear_reset [*4] ##1 !power_up_clear_reset;
  endsequence
  chk_key_puc:
  assert property (wr_go && !key_ok && !power_up_clear_reset |=> puc_pulse) else $error("bad key pulse");
  chk_key_flag:
  assert property (wr_go && !key_ok && power_on_n && pin_reset_n |=> guard_event_flag) else $error("no flag");
  chk_good_store:
  assert property (wr_go && key_ok && !power_up_clear_reset
    |=> ctl_rdata == (($past(ctl_wdata) & 16'h00F7) | 16'h6900)) else $error("store wrong");
  chk_read_key:
  assert property (ctl_rdata[15:8] == rgu_pkg::RGU_KEY_READ) else $error("read key wrong");
  chk_nmi_bits:
  assert property ({nmi_edge, nmi_select} == ctl_rdata[6:5]) else $error("pin bits wrong");
  chk_power_clr:
  assert property (!power_on_n |=> !guard_event_flag) else $error("flag kept");
  chk_pin_clr:
  assert property (!pin_reset_n |=> !guard_event_flag) else $error("flag kept");
  chk_irq_pulse:
  assert property (guard_irq |=> !guard_irq) else $error("irq too long");
  chk_irq_mode:
  assert property (guard_irq |-> $past(ctl_rdata[4]) && guard_event_flag && $past(guard_event_enable))
    else $error("bad irq");
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench for the restart guard
// assumes rgu_pkg, rgu_watchdog and its checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module tb_top;
  logic sys_clk = 0, rstn = 0, power_on_n = 0, pin_reset_n = 1, mclk_tick = 0, aclk_tick = 0;
  logic ctl_sel = 0, ctl_wr = 0, flag_clr = 0, guard_event_enable = 0, due = 0;
  logic [15:0] ctl_wdata = 16'h0000;
  logic [15:0] ctl_rdata;
  logic guard_event_flag, guard_irq, power_up_clear_reset, nmi_select, nmi_edge;
  logic [17:0] exp_q[$];
  logic [17:0] ev;
  logic [7:0] k;
  int fails = 0, checks = 0, n;
  always #2.5 sys_clk = ~sys_clk;
  rgu_watchdog rgu_watchdog_inst (.sys_clk(sys_clk), .rstn(rstn), .power_on_n(power_on_n),
    .pin_reset_n(pin_reset_n), .mclk_tick(mclk_tick), .aclk_tick(aclk_tick), .ctl_sel(ctl_sel),
    .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .flag_clr(flag_clr), .flag_set(1'b0),
    .guard_event_enable(guard_event_enable), .guard_event_flag(guard_event_flag), .guard_irq(guard_irq),
    .power_up_clear_reset(power_up_clear_reset), .nmi_select(nmi_select), .nmi_edge(nmi_edge));
  // strobe left high so calls in a row give back-to-back writes
  task automatic drv(input logic [7:0] key, input logic [7:0] low);
    ctl_sel = 1;
    ctl_wr = 1;
    ctl_wdata = {key, low};
    if (key == 8'h5A)
      exp_q.push_back({8'h69, low & 8'hF7, low[6:5]});
    @(negedge sys_clk);
  endtask
  task automatic one(input logic [7:0] key, input logic [7:0] low);
    drv(key, low);
    ctl_sel = 0;
    ctl_wr = 0;
  endtask
  task automatic clr;
    flag_clr = 1;
    @(negedge sys_clk);
    flag_clr = 0;
  endtask
  task automatic wait_out(input bit on_puc, input int lim);
    n = 0;
    while (n < lim && (on_puc ? power_up_clear_reset : guard_irq) !== 1'b1)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic close_out;
    $display("counts: checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) due <= ctl_sel && ctl_wr && ctl_wdata[15:8] == 8'h5A;
  always @(negedge sys_clk)
    if (due)
    begin
      ev = exp_q.pop_front();
      `CHK({ctl_rdata, nmi_edge, nmi_select}, ev)
    end
  initial
  begin
    #25000;
    fails++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'h5E02));
    repeat (6) @(negedge sys_clk);
    rstn = 1;
    power_on_n = 1;
    `CHK(ctl_rdata, 16'h6900)
    `CHK(guard_event_flag, 1'b0)
    $display("test reset done");
    repeat (8) drv(8'h5A, 8'($urandom));
    one(8'h5A, 8'h00);
    @(negedge sys_clk);
    $display("test keyed writes done");
    k = 8'($urandom);
    one(k == 8'h5A ? 8'hA5 : k, 8'h00);
    `CHK(guard_event_flag, 1'b1)
    `CHK(power_up_clear_reset, 1'b1)
    repeat (3) @(negedge sys_clk);
    `CHK(power_up_clear_reset, 1'b1)
    @(negedge sys_clk);
    `CHK(power_up_clear_reset, 1'b0)
    pin_reset_n = 0;
    @(negedge sys_clk);
    pin_reset_n = 1;
    `CHK(guard_event_flag, 1'b0)
    $display("test bad key done");
    guard_event_enable = 1;
    mclk_tick = 1;
    one(8'h5A, 8'h1B);
    wait_out(0, 200);
    `CHK(n inside {[60:72]}, 1'b1)
    `CHK(guard_event_flag, 1'b1)
    `CHK(power_up_clear_reset, 1'b0)
    guard_event_enable = 0;
    clr();
    wait_out(0, 80);
    `CHK(n, 80)
    `CHK(guard_event_flag, 1'b1)
    $display("test interval mode done");
    mclk_tick = 0;
    aclk_tick = 1;
    clr();
    one(8'h5A, 8'h0F);
    wait_out(1, 200);
    `CHK(n inside {[60:74]}, 1'b1)
    `CHK(guard_event_flag, 1'b1)
    repeat (6) @(negedge sys_clk);
    $display("test watchdog mode done");
    mclk_tick = 1;
    guard_event_enable = 1;
    one(8'h5A, 8'h9A);
    wait_out(0, 600);
    `CHK(n, 600)
    one(8'h5A, 8'h12);
    wait_out(0, 600);
    `CHK(n inside {[505:520]}, 1'b1)
    `CHK(guard_event_flag, 1'b1)
    power_on_n = 0;
    @(negedge sys_clk);
    power_on_n = 1;
    `CHK(guard_event_flag, 1'b0)
    `CHK(exp_q.size(), 0)
    $display("test hold and power-on done");
    close_out();
  end
endmodule
bind rgu_watchdog rgu_watchdog_assertions rgu_watchdog_assertions_inst (.sys_clk(sys_clk), .rstn(rstn),
  .power_on_n(power_on_n), .pin_reset_n(pin_reset_n), .ctl_sel(ctl_sel), .ctl_wr(ctl_wr),
  .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .guard_event_enable(guard_event_enable),
  .guard_event_flag(guard_event_flag), .guard_irq(guard_irq), .power_up_clear_reset(power_up_clear_reset),
  .nmi_select(nmi_select), .nmi_edge(nmi_edge));
`default_nettype wire
